// ---- amp_pkg.sv ----
// Shared constants for the access-mode protection and translation block.
// Assumes a 32-bit APB master and a same-clock execution unit as partner.
package amp_pkg;
  // Two-bit access mode, zero is the most privileged
  typedef logic [1:0] amp_mode_t;
  localparam amp_mode_t MODE_KERNEL = 2'h0;
  localparam amp_mode_t MODE_USER = 2'h3;
  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_KERN_SP = 5'h00;
  localparam logic [4:0] IDX_EXEC_SP = 5'h01;
  localparam logic [4:0] IDX_SUPV_SP = 5'h02;
  localparam logic [4:0] IDX_USER_SP = 5'h03;
  localparam logic [4:0] IDX_INTR_SP = 5'h04;
  localparam logic [4:0] IDX_R0_BASE = 5'h08;
  localparam logic [4:0] IDX_R0_LEN = 5'h09;
  localparam logic [4:0] IDX_R1_BASE = 5'h0a;
  localparam logic [4:0] IDX_R1_LEN = 5'h0b;
  localparam logic [4:0] IDX_SYS_BASE = 5'h0c;
  localparam logic [4:0] IDX_CTX_BASE = 5'h10;
  localparam logic [4:0] IDX_VEC_BASE = 5'h11;
  localparam logic [4:0] IDX_STATUS = 5'h12;
  localparam logic [4:0] IDX_XLT = 5'h13;
  // Status longword fields
  localparam int STAT_CUR_LSB = 24;
  localparam int STAT_PRV_LSB = 22;
  // Page table entry fields
  localparam int PTE_VALID = 31;
  localparam int PTE_PROTECTION_CODE_LSB = 27;
  localparam int PTE_MOD = 26;
  localparam int PFN_W = 21;
  localparam int OFS_W = 9;
  // Virtual address regions in bits 31:30
  localparam logic [1:0] REG_P0 = 2'h0;
  localparam logic [1:0] REG_P1 = 2'h1;
  localparam logic [1:0] REG_SYS = 2'h2;
  // Reset values
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // Translation result codes
  typedef enum logic [1:0] {XR_OK, XR_LEN, XR_INVALID} amp_xres_e;
endpackage : amp_pkg

// ---- amp_top.sv ----
// Access-mode protection checks, per-mode stack pointers, and the
// two-level page walk. Assumes the execution unit and memory share pclk.
`timescale 1ns/10ps
// Operation
// [R1] Four modes, one stack pointer each
// [R2] Inner modes pass checks outer modes fail
// [R3] Mode change only to equal or inner
// [R4] Probe uses lesser-privileged of previous, operand
// [R5] Restored current mode not inner to current
// [R6] Restored previous not inner to restored current
// [R7] Probe mode zero checks previous mode
// [R8] Frame number forms address bits 29:9
// [R9] 30-bit address, or 24 when small
// [R10] Entry: valid, protection, modified, ignored, frame
// [R11] Process walk: examine, form, system, process, address
// [R12] Mode zero kernel, three user
// [R13] Probe failure reported as flag only
module amp_top
  import amp_pkg::*;
#(
  parameter int PA_W = 30
)(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode change request
  input wire logic chm_req,
  input wire amp_pkg::amp_mode_t chm_mode,
  // Probe request and result
  input wire logic prb_req,
  input wire logic prb_write,
  input wire amp_pkg::amp_mode_t prb_mode,
  input wire amp_pkg::amp_mode_t prb_rd_lim,
  input wire amp_pkg::amp_mode_t prb_wr_lim,
  output logic prb_done,
  output logic prb_ok,
  // Return from exception check
  input wire logic rei_req,
  input wire amp_pkg::amp_mode_t rei_cur,
  input wire amp_pkg::amp_mode_t rei_prv,
  output logic rei_done,
  output logic rei_fault,
  // Current and previous mode, and the current mode's stack pointer
  output amp_pkg::amp_mode_t cur_mode,
  output amp_pkg::amp_mode_t prv_mode,
  output logic [31:0] cur_sp,
  // Translation request
  input wire logic xlt_req,
  input wire logic [31:0] xlt_va,
  output logic xlt_busy,
  output logic xlt_done,
  output amp_pkg::amp_xres_e xlt_res,
  output logic [PA_W-1:0] xlt_pa,
  // Page table memory read port
  output logic mem_req,
  output logic [PA_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  import amp_pkg::*;

  initial
  begin
    if (PA_W != 30 && PA_W != 24)
      $error("PA_W must be 30 or 24");
  end

  ////////////////////////////////////////////////////////////////////
  // Register file
  // Storage for printed registers other than status and translation result, addressed by index
  logic [31:0] rf_q [0:31];
  amp_mode_t cur_q; // Current mode
  amp_mode_t prv_q; // Previous mode
  logic [4:0] idx; // Word index of paddr
  logic wr_en; // Write at access edge
  assign idx = paddr[6:2];
  assign wr_en = ce && psel && penable && pwrite;

  // Decoded stored registers; shared by read and write decode
  function automatic logic stored_idx(input logic [4:0] i, input logic [31:0] a);
    stored_idx = (a[31:7] == 25'h0) && (a[1:0] == 2'h0) &&
      (i <= IDX_INTR_SP || (i >= IDX_R0_BASE && i <= IDX_SYS_BASE) ||
       i == IDX_CTX_BASE || i == IDX_VEC_BASE);
  endfunction : stored_idx

  // Any mapped word, including status and translation result
  function automatic logic mapped_idx(input logic [4:0] i, input logic [31:0] a);
    mapped_idx = stored_idx(i, a) || ((a[31:7] == 25'h0) &&
      (a[1:0] == 2'h0) && (i == IDX_STATUS || i == IDX_XLT));
  endfunction : mapped_idx

  // Stored register writes, one flop row per index
  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_rf
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          rf_q[g] <= REG_RST;
        else if (wr_en && idx == 5'(g) && stored_idx(idx, paddr))
          rf_q[g] <= pwdata;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // APB answer: read data captured in setup, ready in access
  logic [31:0] prdata_q;
  logic err_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0;
      err_q <= 1'b0;
    end
    else if (ce && psel && !penable)
    begin
      err_q <= !mapped_idx(idx, paddr);
      if (!mapped_idx(idx, paddr) || pwrite)
        prdata_q <= 32'h0;
      else if (idx == IDX_STATUS)
        prdata_q <= (32'(cur_q) << STAT_CUR_LSB) | (32'(prv_q) << STAT_PRV_LSB);
      else if (idx == IDX_XLT)
        prdata_q <= 32'(xlt_pa);
      else
        prdata_q <= rf_q[idx];
    end
  end
  assign prdata = prdata_q;
  // Stalled while ce is low so no access edge is missed
  assign pready = ce;
  assign pslverr = psel && penable && err_q;

  ////////////////////////////////////////////////////////////////////
  // Status longword: modes from change, return, or software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_q <= MODE_KERNEL;
      prv_q <= MODE_KERNEL;
    end
    else if (ce)
    begin
      if (chm_req)
      begin
        // [R3] Never outward
        // [R12] Lower code is inner
        cur_q <= (chm_mode < cur_q) ? chm_mode : cur_q;
        prv_q <= cur_q;
      end
      else if (rei_req && rei_cur >= cur_q && rei_prv >= rei_cur)
      begin
        // Restore only a status that passed both checks
        cur_q <= rei_cur;
        prv_q <= rei_prv;
      end
      else if (wr_en && idx == IDX_STATUS && mapped_idx(idx, paddr))
      begin
        cur_q <= pwdata[STAT_CUR_LSB +: 2];
        prv_q <= pwdata[STAT_PRV_LSB +: 2];
      end
    end
  end
  assign cur_mode = cur_q;
  assign prv_mode = prv_q;
  // [R1] Stack of the running mode
  assign cur_sp = rf_q[5'(cur_q)];

  ////////////////////////////////////////////////////////////////////
  // Probe: answered one cycle after the request
  amp_mode_t prb_eff; // Maximised probing mode
  logic prb_done_q;
  logic prb_ok_q;
  // [R4] Take the outer mode
  // [R7] Zero yields previous mode
  assign prb_eff = (prb_mode > prv_q) ? prb_mode : prv_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prb_done_q <= 1'b0;
      prb_ok_q <= 1'b0;
    end
    else if (ce)
    begin
      prb_done_q <= prb_req;
      // [R2] Inner modes reach further
      // [R13] Result kept as a flag
      if (prb_req)
        prb_ok_q <= prb_eff <= (prb_write ? prb_wr_lim : prb_rd_lim);
    end
  end
  assign prb_done = prb_done_q;
  assign prb_ok = prb_ok_q;

  ////////////////////////////////////////////////////////////////////
  // Return check, answered one cycle after a request made without chm_req
  logic rei_done_q;
  logic rei_fault_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rei_done_q <= 1'b0;
      rei_fault_q <= 1'b0;
    end
    else if (ce)
    begin
      rei_done_q <= rei_req && !chm_req;
      if (rei_req && !chm_req)
        // [R5] Restored current not inner
        // [R6] Restored previous not inner
        rei_fault_q <= (rei_cur < cur_q) || (rei_prv < rei_cur);
    end
  end
  assign rei_done = rei_done_q;
  assign rei_fault = rei_fault_q;

  ////////////////////////////////////////////////////////////////////
  // Translation walk
  typedef enum logic [2:0] {XS_IDLE, XS_EXAM, XS_SYS_ENT, XS_PROC_ENT, XS_DONE} amp_xs_e;
  amp_xs_e xs_q;
  logic [31:0] va_q; // Operand virtual address
  logic [31:0] pent_va_q; // Virtual address of process entry
  logic [PA_W-1:0] addr_q; // Memory address in flight
  logic [PA_W-1:0] pa_q; // Final physical address
  amp_xres_e res_q;
  logic [31:0] base; // Region base
  logic [31:0] vpn; // Virtual page number
  logic len_bad; // Length check fails
  assign vpn = {11'h0, va_q[29:9]};
  assign base = (va_q[31:30] == REG_P0) ? rf_q[IDX_R0_BASE] : rf_q[IDX_R1_BASE];
  // P1 grows downward, so pages below its length are missing
  assign len_bad = (va_q[31:30] == REG_P0) ? (vpn >= rf_q[IDX_R0_LEN]) :
    (va_q[31:30] == REG_P1) ? (vpn < rf_q[IDX_R1_LEN]) : 1'b0;

  // [R8] Frame number on top of the byte offset
  // [R9] Width set by PA_W
  function automatic logic [PA_W-1:0] frame_pa(input logic [31:0] page_table_entry,
                                                input logic [8:0] ofs);
    frame_pa = PA_W'({page_table_entry[PFN_W-1:0], ofs});
  endfunction : frame_pa

  // [R11] Steps kept in order
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xs_q <= XS_IDLE;
      va_q <= 32'h0;
      pent_va_q <= 32'h0;
      addr_q <= '0;
      pa_q <= '0;
      res_q <= XR_OK;
    end
    else if (ce)
    begin
      unique case (xs_q)
        XS_IDLE:
        begin
          if (xlt_req)
          begin
            va_q <= xlt_va;
            xs_q <= XS_EXAM;
          end
        end
        XS_EXAM:
        begin
          // Step 1 and 2: inspect and form entry virtual address
          pent_va_q <= base + (vpn << 2);
          if (len_bad)
          begin
            res_q <= XR_LEN;
            xs_q <= XS_DONE;
          end
          else if (va_q[31:30] == REG_SYS || va_q[31:30] == 2'h3)
          begin
            // System space needs only its own entry
            addr_q <= PA_W'(rf_q[IDX_SYS_BASE] + (vpn << 2));
            xs_q <= XS_PROC_ENT;
          end
          else
          begin
            // Step 3: system entry mapping the process entry
            addr_q <= PA_W'(rf_q[IDX_SYS_BASE] +
              ({11'h0, (base[29:9] + vpn[29:7])} << 2));
            xs_q <= XS_SYS_ENT;
          end
        end
        XS_SYS_ENT:
        begin
          if (mem_ack)
          begin
            // [R10] Valid bit of the entry
            if (!mem_rdata[PTE_VALID])
            begin
              res_q <= XR_INVALID;
              xs_q <= XS_DONE;
            end
            else
            begin
              // Step 4: address of the process entry
              addr_q <= frame_pa(mem_rdata, pent_va_q[8:0]);
              xs_q <= XS_PROC_ENT;
            end
          end
        end
        XS_PROC_ENT:
        begin
          if (mem_ack)
          begin
            // Step 5: operand physical address
            res_q <= mem_rdata[PTE_VALID] ? XR_OK : XR_INVALID;
            pa_q <= frame_pa(mem_rdata, va_q[8:0]);
            xs_q <= XS_DONE;
          end
        end
        XS_DONE:
        begin
          xs_q <= XS_IDLE;
        end
      endcase
    end
  end
  assign mem_req = (xs_q == XS_SYS_ENT) || (xs_q == XS_PROC_ENT);
  assign mem_addr = addr_q;
  assign xlt_busy = (xs_q != XS_IDLE);
  assign xlt_done = (xs_q == XS_DONE);
  assign xlt_res = res_q;
  assign xlt_pa = pa_q;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence chm_s;
    ce && chm_req;
  endsequence
  mode_never_out_a: assert property (chm_s |=> cur_q <= $past(cur_q)) // [R3]
    else $error("mode change moved outward");
  probe_max_a: assert property (ce && prb_req && !prb_write |=>
    prb_ok == ($past(prb_mode > prv_q ? prb_mode : prv_q) <= $past(prb_rd_lim))) // [R4]
    else $error("probe used wrong mode");
  probe_zero_a: assert property (ce && prb_req && prb_mode == 2'h0 && !chm_req |=>
    prb_done && prb_ok == ($past(prv_q) <= $past(prb_write ? prb_wr_lim : prb_rd_lim))) // [R7]
    else $error("zero probe not at previous mode");
  rei_cur_a: assert property (ce && rei_req && !chm_req && rei_cur < cur_q |=>
    rei_done && rei_fault) // [R5]
    else $error("inner restore not refused");
  rei_prv_a: assert property (ce && rei_req && !chm_req && rei_prv < rei_cur |=>
    rei_fault && cur_q == $past(cur_q)) // [R6]
    else $error("bad previous mode restored");
  sp_sel_a: assert property (cur_sp == ((cur_q == MODE_KERNEL) ? rf_q[IDX_KERN_SP] : // [R1]
    (cur_q == MODE_USER) ? rf_q[IDX_USER_SP] :
    (cur_q == 2'h1) ? rf_q[IDX_EXEC_SP] : rf_q[IDX_SUPV_SP]))
    else $error("stack pointer not of current mode");
  pa_frame_a: assert property (ce && xs_q == XS_PROC_ENT && mem_ack |=>
    xlt_pa == PA_W'({$past(mem_rdata[PFN_W-1:0]), va_q[8:0]})) // [R8]
    else $error("physical address not from frame");
  sequence walk_s;
    xs_q == XS_EXAM ##1 xs_q == XS_SYS_ENT;
  endsequence
  walk_order_a: assert property (walk_s |-> xs_q inside {XS_SYS_ENT, XS_PROC_ENT, XS_DONE}
    ##1 !(xs_q == XS_EXAM)) // [R11]
    else $error("walk steps out of order");
  len_fault_a: assert property (ce && xs_q == XS_EXAM && len_bad |=>
    xs_q == XS_DONE && xlt_res == XR_LEN ##1 xs_q == XS_IDLE) // [R11]
    else $error("length fault not reported");
endmodule : amp_top

// ---- amp_mem_model.sv ----
// Page table memory model answering the translator's fetch port.
// Assumes the bench loads entries into mem by hierarchical write.
`timescale 1ns/10ps
module amp_mem_model #(
  parameter int PA_W = 30
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fetch port and answer delay
  input wire logic mem_req,
  input wire logic [PA_W-1:0] mem_addr,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  // Loaded entries by physical address; unloaded reads give an invalid entry
  logic [31:0] mem [int];
  int cnt;
  ////////////////////////////////////////////////////////////////
  // Ack after lat cycles; data flips when idle so a stale read shows up
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      cnt <= 0;
    end
    else if (mem_req && !mem_ack && cnt >= lat)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : 32'h0;
      cnt <= 0;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt <= (mem_req && !mem_ack) ? cnt + 1 : 0;
    end
  end
endmodule : amp_mem_model

// ---- tb_top.sv ----
// Self-checking bench for the protection and translation block.
// Assumes an APB master, a pulsed execution unit and the memory model.
`timescale 1ns/10ps
module tb_top;
  import amp_pkg::*;
  // Clock, reset, counters
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  int miscompares = 0, num_checks = 0, cyc = 0;
  // APB master
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, cur_sp;
  // Execution unit requests and answers
  logic chm_req = 1'b0, prb_req = 1'b0, prb_write = 1'b0, rei_req = 1'b0, xlt_req = 1'b0;
  amp_mode_t chm_mode = 2'h0, prb_mode = 2'h0, prb_rd_lim = 2'h0, prb_wr_lim = 2'h0;
  amp_mode_t rei_cur = 2'h0, rei_prv = 2'h0, cur_mode, prv_mode;
  logic prb_done, prb_ok, rei_done, rei_fault, xlt_busy, xlt_done, mem_req, mem_ack;
  logic [31:0] xlt_va = 32'h0, mem_rdata;
  amp_xres_e xlt_res;
  logic [29:0] xlt_pa, mem_addr;
  logic [3:0] lat = 4'h0;
  // Bench model: register words and modes
  logic [31:0] mdl [0:31];
  amp_mode_t m_cur, m_prv;
  always #25 pclk = ~pclk;
  amp_top amp_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chm_req(chm_req), .chm_mode(chm_mode),
    .prb_req(prb_req), .prb_write(prb_write), .prb_mode(prb_mode), .prb_rd_lim(prb_rd_lim),
    .prb_wr_lim(prb_wr_lim), .prb_done(prb_done), .prb_ok(prb_ok), .rei_req(rei_req),
    .rei_cur(rei_cur), .rei_prv(rei_prv), .rei_done(rei_done), .rei_fault(rei_fault),
    .cur_mode(cur_mode), .prv_mode(prv_mode), .cur_sp(cur_sp), .xlt_req(xlt_req),
    .xlt_va(xlt_va), .xlt_busy(xlt_busy), .xlt_done(xlt_done), .xlt_res(xlt_res),
    .xlt_pa(xlt_pa), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  amp_mem_model amp_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////
  // Verdict, printed once
  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // Compare one value and count it
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  // Cut a hang short
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end
  // One APB transfer; holds everything until pready is seen high or 100 cycles pass
  task apb(input logic wr, input logic [4:0] idx, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {25'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Wait for a completion pulse: 0 probe, 1 return, 2 translation
  task wait_done(input int w);
    int n;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (!((w == 0 && prb_done === 1'b1) || (w == 1 && rei_done === 1'b1)
             || (w == 2 && xlt_done === 1'b1)) && n < 300);
    if (n >= 300)
      chk(32'h0, 32'h1);
  endtask : wait_done
  // Load both modes through the status word
  task set_modes(input amp_mode_t c, input amp_mode_t p);
    logic [31:0] rd;
    logic err;
    apb(1'b1, IDX_STATUS, {6'h0, c, p, 22'h0}, rd, err);
    m_cur = c;
    m_prv = p;
  endtask : set_modes
  // Translate one address and compare with the bench's walk
  task do_xlt(input logic [31:0] va, input amp_xres_e er, input logic [29:0] epa);
    @(posedge pclk);
    xlt_req <= 1'b1;
    xlt_va <= va;
    @(posedge pclk);
    xlt_req <= 1'b0;
    wait_done(2);
    chk({30'h0, xlt_res}, {30'h0, er});
    if (er == XR_OK)
      chk({2'h0, xlt_pa}, {2'h0, epa});
  endtask : do_xlt
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [4:0] tab [12];
    logic [31:0] rd, wd, a;
    logic err;
    logic [20:0] vpn, spfn, page_frame_number;
    logic [8:0] ofs;
    amp_mode_t c, e;
    amp_xres_e er;
    tab = '{IDX_KERN_SP, IDX_EXEC_SP, IDX_SUPV_SP, IDX_USER_SP, IDX_INTR_SP, IDX_R0_BASE,
            IDX_R0_LEN, IDX_R1_BASE, IDX_R1_LEN, IDX_SYS_BASE, IDX_CTX_BASE, IDX_VEC_BASE};
    void'($urandom(39601));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, write and read back, then an unmapped word
    for (int i = 0; i < 12; i++)
    begin
      apb(1'b0, tab[i], 32'h0, rd, err);
      chk(rd, REG_RST);
      wd = $urandom;
      mdl[tab[i]] = wd;
      apb(1'b1, tab[i], wd, rd, err);
      apb(1'b0, tab[i], 32'h0, rd, err);
      chk(rd, wd);
    end
    apb(1'b1, 5'h05, 32'h1234_5678, rd, err);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 5'h05, 32'h0, rd, err);
    chk(rd, 32'h0);
    // Mode changes only move inward; stack follows mode
    for (int i = 0; i < 12; i++)
    begin
      if (i % 4 == 0)
        set_modes(MODE_USER, MODE_USER);
      @(posedge pclk);
      chm_req <= 1'b1;
      chm_mode <= 2'($urandom_range(3, 0));
      @(posedge pclk);
      chm_req <= 1'b0;
      @(negedge pclk);
      m_prv = m_cur;
      m_cur = (chm_mode < m_cur) ? chm_mode : m_cur;
      chk({30'h0, cur_mode}, {30'h0, m_cur});
      chk({30'h0, prv_mode}, {30'h0, m_prv});
      chk(cur_sp, mdl[{3'h0, m_cur}]);
    end
    // Probes: lesser privilege of previous and operand mode against the limit
    for (int i = 0; i < 24; i++)
    begin
      set_modes(2'($urandom_range(3, 0)), 2'($urandom_range(3, 0)));
      @(posedge pclk);
      prb_req <= 1'b1;
      prb_write <= 1'($urandom);
      prb_mode <= (i % 3 == 0) ? MODE_KERNEL : 2'($urandom_range(3, 0));
      prb_rd_lim <= 2'($urandom_range(3, 0));
      prb_wr_lim <= 2'($urandom_range(3, 0));
      @(posedge pclk);
      prb_req <= 1'b0;
      wait_done(0);
      e = (prb_mode > m_prv) ? prb_mode : m_prv;
      c = prb_write ? prb_wr_lim : prb_rd_lim;
      chk({31'h0, prb_ok}, {31'h0, e <= c});
      chk({30'h0, cur_mode}, {30'h0, m_cur});
    end
    // Return checks on the restored status word
    for (int i = 0; i < 24; i++)
    begin
      set_modes(2'($urandom_range(3, 0)), 2'($urandom_range(3, 0)));
      @(posedge pclk);
      rei_req <= 1'b1;
      rei_cur <= 2'($urandom_range(3, 0));
      rei_prv <= 2'($urandom_range(3, 0));
      @(posedge pclk);
      rei_req <= 1'b0;
      wait_done(1);
      err = (rei_cur < m_cur) || (rei_prv < rei_cur);
      chk({31'h0, rei_fault}, {31'h0, err});
      if (!err)
      begin
        m_cur = rei_cur;
        m_prv = rei_prv;
      end
      chk({28'h0, cur_mode, prv_mode}, {28'h0, m_cur, m_prv});
    end
    // Region 0 walks and one system walk: prompt and slow memory, an invalid entry, the length edge
    apb(1'b1, IDX_SYS_BASE, 32'h0000_4000, rd, err);
    apb(1'b1, IDX_R0_BASE, 32'h8000_2000, rd, err);
    apb(1'b1, IDX_R0_LEN, 32'd200, rd, err);
    for (int i = 0; i < 9; i++)
    begin
      vpn = (i == 7) ? 21'd200 : 21'($urandom_range(199, 0));
      ofs = 9'($urandom);
      spfn = 21'($urandom);
      page_frame_number = 21'($urandom);
      lat <= 4'($urandom_range(3, 0));
      a = 32'h0000_4000 + ({11'h0, 21'h00010} + {18'h0, vpn[20:7]}) * 4;
      if (i == 8)
        a = 32'h0000_4000 + {9'h0, vpn, 2'h0};
      amp_mem_model_inst.mem[int'(a[29:0])] = {1'b1, 4'h0, 1'b0, 5'h0, spfn};
      // ignored span set to ones, frame number in the low bits
      amp_mem_model_inst.mem[int'({spfn, vpn[6:0], 2'h0})] = {i != 5, 10'h3ff, page_frame_number};
      if (i == 8)
        amp_mem_model_inst.mem[int'(a[29:0])] = {1'b1, 10'h3ff, page_frame_number};
      er = (i == 7) ? XR_LEN : (i == 5) ? XR_INVALID : XR_OK;
      do_xlt({(i == 8) ? REG_SYS : REG_P0, vpn, ofs}, er, {page_frame_number, ofs});
    end
    tally_and_finish;
  end
endmodule : tb_top
